// ===== pcm_pkg.sv
// Constants shared by the power and clock manager
package pcm_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_AUX_CONTROL = 8'h8e;
  localparam logic [7:0] IDX_CPU_CLOCK_DIVIDER = 8'h95;
  localparam logic [7:0] IDX_AUX_CONTROL_ONE = 8'ha2;
  localparam logic [9:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_AUX_CONTROL = {IDX_AUX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_CPU_CLOCK_DIVIDER = {IDX_CPU_CLOCK_DIVIDER, 2'b00};
  localparam logic [9:0] ADDR_AUX_CONTROL_ONE = {IDX_AUX_CONTROL_ONE, 2'b00};
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC_BAUD_DOUBLER = 7;
  localparam int PC_FE_VIEW = 6;
  localparam int PC_BROWNOUT_FLAG = 5;
  localparam int PC_POWERON_FLAG = 4;
  localparam int PC_USER_FLAG_ONE = 3;
  localparam int PC_USER_FLAG_ZERO = 2;
  localparam int PC_POWERDOWN = 1;
  localparam int PC_IDLE = 0;
  localparam int AUX_LOWVOLT_MEM = 4;
  localparam int AUX1_BROWNOUT_DISABLE = 6;
  localparam int AUX1_BROWNOUT_IRQ_SEL = 5;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PC_RST_POWERON = 8'h30;
  localparam logic [7:0] PC_RST_BROWNOUT = 8'h20;
  localparam logic [7:0] PC_RST_OTHER = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  // ----------------------------------------------------------------
  // Timing counts: stabilisation in oscillator clocks, machine cycle in CPU clocks
  // ----------------------------------------------------------------
  localparam logic [10:0] STAB_CLKS_XTAL = 11'h400;
  localparam logic [10:0] STAB_CLKS_RC = 11'h100;
  localparam logic [2:0] CLKS_PER_MCYCLE = 3'h6;
  localparam int NUM_SYNC = 4;
  localparam int SY_BELOW_LOW = 0;
  localparam int SY_BELOW_HIGH = 1;
  localparam int SY_EXT_RST = 2;
  localparam int SY_WDT_OVF = 3;
endpackage

// ===== pcm_power_clock_manager.sv
// Power and clock manager: clock division, supply monitors, power modes
// ------------------------------------------------------------------
// Behaviour
// R01 - Compat bit halves clock, twelve-clock cycles
// R02 - Divider zero: oscillator rate or half
// R03 - Divider N: divide by 2(N+1)
// R04 - New divider value applied without stalling
// R05 - Brownout resets, or interrupts when selected
// R06 - Reset held while low; interrupt once
// R07 - Brownout interrupt needs both enable bits
// R08 - Brownout sets sticky flag until cleared
// R09 - Level bit 1 selects 2.5 V, 0 3.8 V
// R10 - Disable bit suppresses all brownout action
// R11 - Power-up sets sticky power-on flag
// R12 - Idle halts CPU; interrupt or reset ends
// R13 - Power-down bit stops oscillator and logic
// R14 - Reset or enabled wake interrupt leaves power-down
// R15 - Watchdog overflow resets even in power-down
// R16 - Brownout resets or wakes in power-down
// R17 - Wake waits 1024 or 256 clocks
// R18 - Watchdog and brownout wake conditions
// R19 - Converter wakes only on RC clock, enabled
// R20 - Memory saver bit cleared only at power-on
// R21 - Control resets 30H, 20H or 00H
// R22 - Baud doubler and framing-error view bits
// R23 - Mode bits self-clear when mode ends
// R24 - Two user flags, software only
// R25 - Zero clears flags, one leaves them
// ------------------------------------------------------------------
`timescale 1ns/10ps
module pcm_power_clock_manager
  import pcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic compat_half_clock,
  input wire logic brownout_level_select,
  input wire logic watchdog_reset_enable,
  input wire logic osc_is_crystal,
  input wire logic supply_below_low,
  input wire logic supply_below_high,
  input wire logic ext_reset_n,
  input wire logic wdt_overflow,
  input wire logic wdt_irq_enable,
  input wire logic global_irq_enable,
  input wire logic brownout_irq_enable,
  input wire logic idle_wake_irq,
  input wire logic pd_wake_irq,
  input wire logic adc_done,
  input wire logic adc_irq_enable,
  input wire logic converter_rc_clock_select,
  output logic sys_reset,
  output logic brownout_irq,
  output logic cpu_tick,
  output logic periph_tick,
  output logic cpu_halt,
  output logic osc_enable,
  output logic baud_doubler,
  output logic framing_error_view_select,
  output logic lowvolt_memory_saver
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic [NUM_SYNC-1:0] sy_raw;
  logic [NUM_SYNC-1:0] sy_meta_q;
  logic [NUM_SYNC-1:0] sy_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign sy_raw = {wdt_overflow, ~ext_reset_n, supply_below_high, supply_below_low};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_sync_q)
      begin
        if (!rst_sync_q)
        begin
          sy_meta_q[gi] <= 1'b0;
          sy_q[gi] <= 1'b0;
        end
        else
        begin
          sy_meta_q[gi] <= sy_raw[gi];
          sy_q[gi] <= sy_meta_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] pc_q;
  logic [7:0] div_q;
  logic lowvolt_q;
  logic bod_q;
  logic boi_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_en;
  logic wr_pc;
  logic [7:0] wd;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en = avs_write & ack_q & avs_byteenable[0];
  assign wr_pc = wr_en & (avs_address == ADDR_POWER_CONTROL);
  assign wd = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Brownout detection
  // ----------------------------------------------------------------
  logic below;
  logic bo_det;
  logic bo_prev_q;
  logic bo_rise;
  logic bo_rst;
  logic bo_irq_ok;
  logic wdt_prev_q;
  logic wdt_rise;
  logic wdt_rst;
  logic other_rst;

  assign below = brownout_level_select ? sy_q[SY_BELOW_LOW] : sy_q[SY_BELOW_HIGH]; // [R09]
  assign bo_det = below & ~bod_q; // [R10]
  assign bo_rise = bo_det & ~bo_prev_q;
  assign bo_rst = bo_det & ~boi_q; // [R05] [R06] [R16] [R18]
  assign bo_irq_ok = bo_rise & boi_q & global_irq_enable & brownout_irq_enable; // [R07]
  assign wdt_rise = sy_q[SY_WDT_OVF] & ~wdt_prev_q;
  assign wdt_rst = wdt_rise & watchdog_reset_enable; // [R15] [R18]
  assign other_rst = bo_rst | wdt_rst | sy_q[SY_EXT_RST];

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      bo_prev_q <= 1'b0;
      wdt_prev_q <= 1'b0;
    end
    else
    begin
      bo_prev_q <= bo_det;
      wdt_prev_q <= sy_q[SY_WDT_OVF];
    end
  end

  // One pulse per falling crossing
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      brownout_irq <= 1'b0;
    else
      brownout_irq <= bo_irq_ok; // [R05] [R06]
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      sys_reset <= 1'b1;
    else
      sys_reset <= other_rst; // [R06] [R15] [R16]
  end

  // ----------------------------------------------------------------
  // Power-down wake and oscillator stabilisation
  // ----------------------------------------------------------------
  logic stab_q;
  logic [10:0] stab_cnt_q;
  logic [10:0] stab_len;
  logic wake_evt;
  logic stab_done;
  logic idle_end;

  assign stab_len = osc_is_crystal ? STAB_CLKS_XTAL : STAB_CLKS_RC; // [R17]
  assign stab_done = stab_q & (stab_cnt_q == stab_len - 11'h001);
  assign wake_evt = pd_wake_irq // [R14]
    | bo_irq_ok // [R16]
    | (wdt_rise & ~watchdog_reset_enable & wdt_irq_enable) // [R18]
    | (adc_done & converter_rc_clock_select & adc_irq_enable); // [R19]
  assign idle_end = idle_wake_irq | bo_irq_ok; // [R12]

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      stab_q <= 1'b0;
      stab_cnt_q <= 11'h000;
    end
    else if (other_rst)
    begin
      stab_q <= pc_q[PC_POWERDOWN] | stab_q; // [R15] [R17]
      stab_cnt_q <= 11'h000;
    end
    else if (pc_q[PC_POWERDOWN] & ~stab_q & wake_evt)
    begin
      stab_q <= 1'b1; // [R17]
      stab_cnt_q <= 11'h000;
    end
    else if (stab_done)
    begin
      stab_q <= 1'b0;
      stab_cnt_q <= 11'h000;
    end
    else if (stab_q)
      stab_cnt_q <= stab_cnt_q + 11'h001; // [R17]
  end

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      pc_q <= PC_RST_POWERON; // [R11] [R21]
    else if (bo_rst)
      pc_q <= PC_RST_BROWNOUT; // [R08] [R21]
    else if (other_rst)
      pc_q <= PC_RST_OTHER; // [R21]
    else
    begin
      if (wr_pc)
      begin
        pc_q[PC_BAUD_DOUBLER] <= wd[PC_BAUD_DOUBLER]; // [R22]
        pc_q[PC_FE_VIEW] <= wd[PC_FE_VIEW]; // [R22]
        pc_q[PC_USER_FLAG_ONE] <= wd[PC_USER_FLAG_ONE]; // [R24]
        pc_q[PC_USER_FLAG_ZERO] <= wd[PC_USER_FLAG_ZERO]; // [R24]
      end
      // Hardware set wins over a software clear
      if (bo_rise)
        pc_q[PC_BROWNOUT_FLAG] <= 1'b1; // [R08]
      else if (wr_pc & ~wd[PC_BROWNOUT_FLAG])
        pc_q[PC_BROWNOUT_FLAG] <= 1'b0; // [R25]
      if (wr_pc & ~wd[PC_POWERON_FLAG])
        pc_q[PC_POWERON_FLAG] <= 1'b0; // [R25]
      if (stab_done)
        pc_q[PC_POWERDOWN] <= 1'b0; // [R23]
      else if (wr_pc)
        pc_q[PC_POWERDOWN] <= wd[PC_POWERDOWN]; // [R13]
      if (wr_pc)
        pc_q[PC_IDLE] <= wd[PC_IDLE]; // [R12]
      else if (idle_end)
        pc_q[PC_IDLE] <= 1'b0; // [R12] [R23]
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary and divider registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      lowvolt_q <= 1'b0;
    else if (wr_en & (avs_address == ADDR_AUX_CONTROL) & wd[AUX_LOWVOLT_MEM])
      lowvolt_q <= 1'b1; // [R20]
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      bod_q <= 1'b0;
      boi_q <= 1'b0;
    end
    else if (sy_q[SY_EXT_RST] | wdt_rst)
    begin
      bod_q <= 1'b0;
      boi_q <= 1'b0;
    end
    else if (wr_en & (avs_address == ADDR_AUX_CONTROL_ONE))
    begin
      bod_q <= wd[AUX1_BROWNOUT_DISABLE]; // [R10]
      boi_q <= wd[AUX1_BROWNOUT_IRQ_SEL]; // [R05]
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      div_q <= DIV_RST;
    else if (other_rst)
      div_q <= DIV_RST;
    else if (wr_en & (avs_address == ADDR_CPU_CLOCK_DIVIDER))
      div_q <= wd; // [R04]
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      rdata_q <= 32'h0000_0000;
    else if (avs_read & ~ack_q)
    begin
      unique case (avs_address)
        ADDR_POWER_CONTROL: rdata_q <= {24'h00_0000, pc_q};
        ADDR_AUX_CONTROL: rdata_q <= {27'h000_0000, lowvolt_q, 4'h0};
        ADDR_CPU_CLOCK_DIVIDER: rdata_q <= {24'h00_0000, div_q};
        ADDR_AUX_CONTROL_ONE: rdata_q <= {25'h000_0000, bod_q, boi_q, 5'h00};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // CPU clock division
  // ----------------------------------------------------------------
  logic osc_run;
  logic half_q;
  logic pre_tick;
  logic [8:0] cnt_q;
  logic [8:0] limit;
  logic div_tick;
  logic [2:0] mc_q;

  assign osc_run = ~pc_q[PC_POWERDOWN] | stab_q; // [R13]
  assign pre_tick = osc_run & (~compat_half_clock | half_q); // [R01] [R02]
  // Terminal count 2N+1 gives a ratio of 2(N+1)
  assign limit = (div_q == 8'h00) ? 9'h000 : {div_q, 1'b1}; // [R02] [R03]
  // A value below the running count ends the period at once
  assign div_tick = pre_tick & (cnt_q >= limit); // [R04]

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      half_q <= 1'b0;
    else if (osc_run)
      half_q <= ~half_q; // [R01]
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      cnt_q <= 9'h000;
    else if (div_tick)
      cnt_q <= 9'h000;
    else if (pre_tick)
      cnt_q <= cnt_q + 9'h001; // [R03]
  end

  // Machine cycle of six CPU clocks keeps running in idle
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      mc_q <= 3'h0;
    else if (div_tick & ~stab_q)
      mc_q <= (mc_q == CLKS_PER_MCYCLE - 3'h1) ? 3'h0 : mc_q + 3'h1; // [R01]
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      cpu_tick <= 1'b0;
      periph_tick <= 1'b0;
    end
    else
    begin
      cpu_tick <= div_tick & ~cpu_halt & ~stab_q & ~other_rst; // [R12] [R13] [R17]
      periph_tick <= div_tick & ~stab_q & (mc_q == CLKS_PER_MCYCLE - 3'h1);
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  assign cpu_halt = pc_q[PC_IDLE] | pc_q[PC_POWERDOWN]; // [R12] [R17]
  assign osc_enable = osc_run; // [R13] [R17]
  assign baud_doubler = pc_q[PC_BAUD_DOUBLER]; // [R22]
  assign framing_error_view_select = pc_q[PC_FE_VIEW]; // [R22]
  assign lowvolt_memory_saver = lowvolt_q; // [R20]

endmodule // pcm_power_clock_manager

// ===== pcm_power_clock_manager_asserts.sv
// Port checker for the power and clock manager
`timescale 1ns/10ps
module pcm_checker
  import pcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic global_irq_enable,
  input wire logic brownout_irq_enable,
  input wire logic sys_reset,
  input wire logic brownout_irq,
  input wire logic cpu_tick,
  input wire logic periph_tick,
  input wire logic cpu_halt,
  input wire logic osc_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Cycles since the oscillator came back
  // ----------------------------------------------------------------
  logic [11:0] stab_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stab_q <= 12'hfff;
    else if (!osc_enable)
      stab_q <= 12'h000;
    else if (stab_q != 12'hfff)
      stab_q <= stab_q + 12'h001;
  end
  a_irq_one_pulse:
    assert property (brownout_irq |=> !brownout_irq) else $error("brownout irq too long");
  a_irq_needs_enables:
    assert property (brownout_irq |-> $past(global_irq_enable) && $past(brownout_irq_enable))
    else $error("brownout irq while disabled");
  a_irq_not_reset:
    assert property (brownout_irq |-> !sys_reset) else $error("brownout irq during reset");
  a_osc_off_halts:
    assert property (!osc_enable |-> cpu_halt) else $error("oscillator off but cpu not halted");
  a_osc_off_still:
    assert property (!osc_enable[*2] |-> !cpu_tick && !periph_tick)
    else $error("ticks while oscillator off");
  a_halt_no_tick:
    assert property (cpu_halt[*2] |-> !cpu_tick) else $error("cpu tick while halted");
  a_wake_waits_stab:
    assert property (cpu_tick |-> stab_q >= 12'h0f8) else $error("cpu resumed before stable");
  a_one_wait_cycle:
    assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_upper_read_zero:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  c_irq: cover property (brownout_irq);
  c_osc_off: cover property (!osc_enable);
  c_wake: cover property ($fell(cpu_halt));
endmodule // pcm_checker

bind pcm_power_clock_manager pcm_checker i_chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .global_irq_enable(global_irq_enable), .brownout_irq_enable(brownout_irq_enable),
  .sys_reset(sys_reset), .brownout_irq(brownout_irq), .cpu_tick(cpu_tick),
  .periph_tick(periph_tick), .cpu_halt(cpu_halt), .osc_enable(osc_enable));

// ===== pcm_power_clock_manager_tb.sv
// Self-checking testbench for the power and clock manager
`timescale 1ns/10ps
module pcm_power_clock_manager_tb
  import pcm_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic compat_half_clock = 1'b0, brownout_level_select = 1'b1, watchdog_reset_enable = 1'b0;
  logic osc_is_crystal = 1'b0, supply_below_low = 1'b0, supply_below_high = 1'b0;
  logic ext_reset_n = 1'b1, wdt_overflow = 1'b0, wdt_irq_enable = 1'b0;
  logic global_irq_enable = 1'b1, brownout_irq_enable = 1'b1, idle_wake_irq = 1'b0;
  logic pd_wake_irq = 1'b0, adc_done = 1'b0, adc_irq_enable = 1'b0;
  logic converter_rc_clock_select = 1'b0;
  logic avs_waitrequest, sys_reset, brownout_irq, cpu_tick, periph_tick, cpu_halt;
  logic osc_enable, baud_doubler, framing_error_view_select, lowvolt_memory_saver;
  int failures = 0, n_checks = 0, cyc = 0, n, p;
  integer seed = 32'h2c39;
  logic [7:0] dv;
  logic cp;

  pcm_power_clock_manager i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .compat_half_clock(compat_half_clock),
    .brownout_level_select(brownout_level_select),
    .watchdog_reset_enable(watchdog_reset_enable), .osc_is_crystal(osc_is_crystal),
    .supply_below_low(supply_below_low), .supply_below_high(supply_below_high),
    .ext_reset_n(ext_reset_n), .wdt_overflow(wdt_overflow),
    .wdt_irq_enable(wdt_irq_enable), .global_irq_enable(global_irq_enable),
    .brownout_irq_enable(brownout_irq_enable), .idle_wake_irq(idle_wake_irq),
    .pd_wake_irq(pd_wake_irq), .adc_done(adc_done), .adc_irq_enable(adc_irq_enable),
    .converter_rc_clock_select(converter_rc_clock_select), .sys_reset(sys_reset),
    .brownout_irq(brownout_irq), .cpu_tick(cpu_tick), .periph_tick(periph_tick),
    .cpu_halt(cpu_halt), .osc_enable(osc_enable), .baud_doubler(baud_doubler),
    .framing_error_view_select(framing_error_view_select),
    .lowvolt_memory_saver(lowvolt_memory_saver));

  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_rng(input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      failures++;
      $display("BAD t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
    end
  endtask

  // Avalon transfer: hold until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
    begin
      failures++;
      report_and_stop();
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk8(e, q);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return cpu_tick;
      1: return brownout_irq;
      2: return sys_reset;
      3: return cpu_halt;
      4: return osc_enable;
      default: return periph_tick;
    endcase
  endfunction

  // Cycles until a watched output reaches a level, seen at falling edges
  task automatic wait_lvl(input int k, input logic v, input int lim, output int c);
    c = 0;
    @(negedge clk);
    while (sig(k) !== v && c < lim)
    begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
  endtask

  task automatic count_hi(input int k, input int cycles, output int c);
    c = 0;
    repeat (cycles)
    begin
      @(negedge clk);
      if (sig(k) === 1'b1)
        c++;
    end
    @(posedge clk);
  endtask

  function automatic int period(input logic c, input logic [7:0] d);
    return (c ? 2 : 1) * ((d == 8'h00) ? 1 : 2 * (int'(d) + 1));
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(ADDR_POWER_CONTROL, PC_RST_POWERON);
    rchk(ADDR_CPU_CLOCK_DIVIDER, DIV_RST);
    rchk(ADDR_AUX_CONTROL, 8'h00);
    rchk(ADDR_AUX_CONTROL_ONE, 8'h00);
    wr(10'h3fc, 8'hff);
    rchk(10'h3fc, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'hcc);
    rchk(ADDR_POWER_CONTROL, 8'hcc);
    chk8(8'h03, {6'h0, baud_doubler, framing_error_view_select});
    wr(ADDR_POWER_CONTROL, 8'h30);
    rchk(ADDR_POWER_CONTROL, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      dv = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : 8'($random(seed));
      cp = (i == 2) ? 1'b1 : 1'($random(seed));
      compat_half_clock <= cp;
      wr(ADDR_CPU_CLOCK_DIVIDER, dv);
      wait_lvl(0, 1'b1, 1100, n);
      wait_lvl(0, 1'b1, 1100, n);
      wait_lvl(0, 1'b1, 1100, n);
      p = period(cp, dv);
      chk_rng(p - 1, p - 1, n);
    end
    compat_half_clock <= 1'b0;
    wr(ADDR_CPU_CLOCK_DIVIDER, 8'h00);
    wr(ADDR_AUX_CONTROL, 8'h10);
    chk8(8'h01, {7'h0, lowvolt_memory_saver});
    wr(ADDR_POWER_CONTROL, 8'h01);
    chk8(8'h01, {7'h0, cpu_halt});
    count_hi(5, 24, n);
    chk_rng(4, 4, n);
    idle_wake_irq <= 1'b1;
    wait_lvl(3, 1'b0, 20, n);
    idle_wake_irq <= 1'b0;
    chk_rng(0, 5, n);
    rchk(ADDR_POWER_CONTROL, 8'h00);
    for (int x = 0; x < 2; x++)
    begin
      osc_is_crystal <= x[0];
      wr(ADDR_POWER_CONTROL, 8'h02);
      wait_lvl(4, 1'b0, 10, n);
      chk_rng(0, 5, n);
      adc_done <= 1'b1;
      adc_irq_enable <= 1'b1;
      count_hi(0, 20, n);
      chk_rng(0, 0, n);
      pd_wake_irq <= !x[0];
      converter_rc_clock_select <= x[0];
      wait_lvl(0, 1'b1, 1100, n);
      pd_wake_irq <= 1'b0;
      adc_done <= 1'b0;
      converter_rc_clock_select <= 1'b0;
      p = x ? int'(STAB_CLKS_XTAL) : int'(STAB_CLKS_RC);
      chk_rng(p - 2, p + 8, n);
      rchk(ADDR_POWER_CONTROL, 8'h00);
    end
    watchdog_reset_enable <= 1'b1;
    wr(ADDR_POWER_CONTROL, 8'h02);
    wdt_overflow <= 1'b1;
    wait_lvl(2, 1'b1, 12, n);
    chk_rng(0, 8, n);
    wdt_overflow <= 1'b0;
    wait_lvl(2, 1'b0, 20, n);
    wait_lvl(0, 1'b1, 1100, n);
    rchk(ADDR_POWER_CONTROL, PC_RST_OTHER);
    chk8(8'h01, {7'h0, lowvolt_memory_saver});
    for (int k = 0; k < 3; k++)
    begin
      brownout_level_select <= k[0];
      global_irq_enable <= (k != 2);
      wr(ADDR_AUX_CONTROL_ONE, 8'h20);
      if (k[0])
        supply_below_high <= 1'b1;
      else
        supply_below_low <= 1'b1;
      count_hi(1, 20, n);
      chk_rng(0, 0, n);
      supply_below_low <= 1'b1;
      supply_below_high <= 1'b1;
      count_hi(1, 30, n);
      chk_rng((k != 2), (k != 2), n);
      chk8(8'h00, {7'h0, sys_reset});
      supply_below_low <= 1'b0;
      supply_below_high <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(ADDR_POWER_CONTROL, 8'h20);
      wr(ADDR_POWER_CONTROL, 8'h00);
    end
    global_irq_enable <= 1'b1;
    brownout_level_select <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_AUX_CONTROL_ONE, j ? 8'h40 : 8'h60);
      supply_below_low <= 1'b1;
      count_hi(1, 30, n);
      chk_rng(0, 0, n);
      chk8(8'h00, {7'h0, sys_reset});
      supply_below_low <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(ADDR_POWER_CONTROL, 8'h00);
    end
    wr(ADDR_AUX_CONTROL_ONE, 8'h00);
    supply_below_low <= 1'b1;
    wait_lvl(2, 1'b1, 12, n);
    repeat (40) @(posedge clk);
    chk8(8'h01, {7'h0, sys_reset});
    supply_below_low <= 1'b0;
    wait_lvl(2, 1'b0, 20, n);
    repeat (4) @(posedge clk);
    rchk(ADDR_POWER_CONTROL, PC_RST_BROWNOUT);
    report_and_stop();
  end
endmodule // pcm_power_clock_manager_tb
